// file: tb/amp_plant.sv
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_plant (
   input wire logic hclk,
   input wire logic [`AMP_NAXES*32-1:0] cmd_pos,
   input wire logic [31:0] lag,
   input wire logic [`AMP_NAXES-1:0] lag_on,
   input wire logic [`AMP_NAXES-1:0] fwd_hit,
   input wire logic [`AMP_NAXES-1:0] rev_hit,
   input wire logic pol_high,
   output logic [`AMP_NAXES*32-1:0] act_pos,
   output logic [`AMP_NAXES-1:0] fwd_sw_in,
   output logic [`AMP_NAXES-1:0] rev_sw_in
);
   // Encoder follows the command with an optional lag
   always_ff @(posedge hclk) begin
      for (int a = 0; a < `AMP_NAXES; a++) begin
         act_pos[a*32+:32] <= cmd_pos[a*32+:32] - (lag_on[a] ? lag : 32'h0);
      end
   end
   // Switch contacts at the wired active level
   assign fwd_sw_in = pol_high ? fwd_hit : ~fwd_hit;
   assign rev_sw_in = pol_high ? rev_hit : ~rev_hit;
endmodule : amp_plant

// file: tb/amp_top_sva.sv
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_top_chk (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic abort_n,
   input wire logic watchdog,
   input wire logic [`AMP_NAXES-1:0] amplifier_enable_n,
   input wire logic [`AMP_NAXES-1:0] motion_stop,
   input wire logic [`AMP_NAXES*32-1:0] drive_out,
   input wire logic [2:0] routine
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wd_held;
      watchdog [*4];
   endsequence
   sequence s_abort_held;
      !abort_n [*4];
   endsequence
   a_wd_amp_off: assert property (s_wd_held |=> &amplifier_enable_n)
      else $error("amp enable active under watchdog");
   a_abort_stop: assert property (s_abort_held |=> &motion_stop)
      else $error("motion not stopped on abort");
   a_reset_state: assert property ($rose(hresetn) |-> &amplifier_enable_n && routine == 3'h1)
      else $error("wrong state after reset");
   a_off_drive0: assert property (amplifier_enable_n[0] [*2] |-> drive_out[31:0] == 32'h0)
      else $error("axis 0 drives while disabled");
   a_off_drive3: assert property (amplifier_enable_n[3] [*2] |-> drive_out[127:96] == 32'h0)
      else $error("axis 3 drives while disabled");
   a_routine_onehot: assert property ($onehot(routine))
      else $error("routine state not one-hot");
   a_ready_high: assert property (hreadyout)
      else $error("bus stalled");
   a_resp_okay: assert property (!hresp)
      else $error("bus error response");
endmodule : amp_top_chk
bind amp_top amp_top_chk amp_top_chk_inst (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .abort_n(abort_n), .watchdog(watchdog),
   .amplifier_enable_n(amplifier_enable_n), .motion_stop(motion_stop),
   .drive_out(drive_out), .routine(routine));

// file: tb/amp_top_test.sv
`timescale 1ns/1ps
`include "amp_cfg.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_count++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module amp_top_test;
   logic hclk, hresetn, hsel, hwrite, abort_n, watchdog, pol_high, hready, hresp, hreadyout, irq;
   logic [1:0] htrans;
   logic [2:0] hsize, routine;
   logic [31:0] haddr, hwdata, hrdata, lag, q;
   logic [3:0] move_fwd, move_rev, fwd_hit, rev_hit, lag_on, fwd_sw_in, rev_sw_in;
   logic [3:0] amplifier_enable_n, inhibit_fwd, inhibit_rev, motion_stop;
   logic [127:0] cmd_pos, act_pos, drive_out;
   int err_count, comparisons;
   assign hready = hreadyout;
   amp_top amp_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .abort_n(abort_n),
      .fwd_sw_in(fwd_sw_in), .rev_sw_in(rev_sw_in), .watchdog(watchdog), .cmd_pos(cmd_pos),
      .act_pos(act_pos), .move_fwd(move_fwd), .move_rev(move_rev),
      .amplifier_enable_n(amplifier_enable_n), .inhibit_fwd(inhibit_fwd),
      .inhibit_rev(inhibit_rev), .motion_stop(motion_stop), .drive_out(drive_out),
      .routine(routine), .irq(irq));
   amp_plant amp_plant_inst (.hclk(hclk), .cmd_pos(cmd_pos), .lag(lag), .lag_on(lag_on),
      .fwd_hit(fwd_hit), .rev_hit(rev_hit), .pol_high(pol_high), .act_pos(act_pos),
      .fwd_sw_in(fwd_sw_in), .rev_sw_in(rev_sw_in));
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : final_report
   task rdy(output logic [31:0] d);
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            err_count++;
            final_report;
         end
         @(negedge hclk);
      end
      d = hrdata;
      @(posedge hclk);
   endtask : rdy
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      logic [31:0] unused_d;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      rdy(unused_d);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy(q);
   endtask : bus
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] ex, input string nm);
      bus(1'b0, a, 32'h0);
      `CHK(nm, ex, q)
   endtask : rd
   task settle;
      repeat (6) @(posedge hclk);
      #1;
   endtask : settle
   function automatic logic [11:0] ax(input int i, input logic [11:0] off);
      ax = `AMP_A_AXBASE + 12'(i) * `AMP_A_AXSTEP + off;
   endfunction : ax
   initial begin
      #200000 err_count++;
      final_report;
   end
   initial begin
      hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hsize = 3'h2;
      hwdata = 32'h0; abort_n = 1'b1; watchdog = 1'b0; cmd_pos = '0; move_fwd = 4'h0;
      move_rev = 4'h0; lag = 32'hC8; lag_on = 4'h0; fwd_hit = 4'h0; rev_hit = 4'h0;
      pol_high = 1'b0; err_count = 0; comparisons = 0;
      repeat (3) @(posedge hclk);
      `CHK("amp_en_rst", 4'hF, amplifier_enable_n)
      hresetn <= 1'b1;
      rd(ax(0, `AMP_AX_FWD), 32'h7FFFFFFF, "fwd_lim");
      rd(ax(3, `AMP_AX_REV), 32'h80000000, "rev_lim");
      rd(ax(1, `AMP_AX_ERL), 32'h00004000, "err_lim");
      rd(12'h0F0, 32'h0, "unmapped");
      $display("test reset done");
      wr(`AMP_A_CMD, 32'hF);
      wr(ax(0, `AMP_AX_CFG), 32'h1);
      wr(ax(0, `AMP_AX_ERL), 32'h64);
      wr(ax(1, `AMP_AX_ERL), 32'h64);
      wr(`AMP_A_MASK, 32'h1);
      settle();
      `CHK("amp_on", 4'h0, amplifier_enable_n)
      lag_on <= 4'h3;
      settle();
      `CHK("amp_err", 4'h3, amplifier_enable_n)
      `CHK("err_rtn", 3'h2, routine)
      `CHK("irq_err", 1'b1, irq)
      wr(`AMP_A_CTRL, 32'h4);
      settle();
      `CHK("err_again", 3'h2, routine)
      lag_on <= 4'h0;
      settle();
      wr(`AMP_A_STAT, 32'h1);
      wr(`AMP_A_CTRL, 32'h4);
      settle();
      `CHK("resume", 3'h1, routine)
      `CHK("irq_clr", 1'b0, irq)
      `CHK("amp_latched", 4'h1, amplifier_enable_n)
      wr(`AMP_A_CMD, 32'h1);
      settle();
      `CHK("servo_here", 4'h0, amplifier_enable_n)
      $display("test error done");
      abort_n <= 1'b0;
      settle();
      `CHK("abort_stop", 4'hF, motion_stop)
      `CHK("abort_amp", 4'h1, amplifier_enable_n)
      abort_n <= 1'b1;
      wr(`AMP_A_CMD, 32'h1);
      wr(`AMP_A_CTRL, 32'h2);
      settle();
      `CHK("abort_cmd", 4'h1, amplifier_enable_n)
      wr(`AMP_A_CTRL, 32'h8);
      settle();
      `CHK("ctl_reset", 4'h0, amplifier_enable_n)
      $display("test abort done");
      wr(ax(2, `AMP_AX_FWD), 32'h3E8);
      cmd_pos[95:64] <= 32'h3E8;
      settle();
      `CHK("soft_stop", 4'h4, inhibit_fwd)
      wr(`AMP_A_MASK, 32'h4);
      wr(`AMP_A_TGT, 32'h1F4);
      wr(`AMP_A_CMD, 32'h60);
      rd(`AMP_A_STAT, 32'h0, "tgt_ok");
      wr(`AMP_A_TGT, 32'h7D0);
      wr(`AMP_A_CMD, 32'h60);
      rd(`AMP_A_STAT, 32'h4, "tgt_refused");
      settle();
      `CHK("irq_tgt", 1'b1, irq)
      wr(`AMP_A_STAT, 32'h4);
      settle();
      `CHK("irq_w1c", 1'b0, irq)
      $display("test limits done");
      cmd_pos[95:64] <= 32'h0;
      move_fwd <= 4'h8;
      fwd_hit <= 4'h8;
      settle();
      `CHK("sw_inhibit", 4'h8, inhibit_fwd)
      `CHK("lim_rtn", 3'h4, routine)
      rd(`AMP_A_SW, 32'h80, "sw_state");
      pol_high <= 1'b1;
      wr(`AMP_A_CTRL, 32'h5);
      rev_hit <= 4'h1;
      settle();
      rd(`AMP_A_SW, 32'h81, "sw_pol");
      `CHK("rev_inhibit", 4'h1, inhibit_rev)
      $display("test switch done");
      wr(ax(1, `AMP_AX_OFS), 32'h10);
      settle();
      `CHK("ofs_drive", 32'h10, drive_out[63:32])
      wr(ax(1, `AMP_AX_CFG), 32'h2);
      cmd_pos[63:32] <= 32'h20;
      settle();
      `CHK("rev_drive", 32'h50, drive_out[63:32])
      rd(ax(1, `AMP_AX_ERR), 32'h40, "rev_err");
      $display("test drive done");
      watchdog <= 1'b1;
      settle();
      `CHK("watchdog", 4'hF, amplifier_enable_n)
      watchdog <= 1'b0;
      $display("test watchdog done");
      final_report;
   end
endmodule : amp_top_test

// file: verilog/amp_cfg.svh
`ifndef AMP_CFG_SVH
`define AMP_CFG_SVH
`define AMP_NAXES 4
`define AMP_PW 32
`define AMP_A_CTRL 12'h000
`define AMP_A_CMD 12'h004
`define AMP_A_STAT 12'h008
`define AMP_A_MASK 12'h00C
`define AMP_A_SW 12'h010
`define AMP_A_DRV 12'h014
`define AMP_A_TGT 12'h018
`define AMP_A_AXBASE 12'h100
`define AMP_A_AXSTEP 12'h020
`define AMP_AX_FWD 12'h000
`define AMP_AX_REV 12'h004
`define AMP_AX_ERL 12'h008
`define AMP_AX_OFS 12'h00C
`define AMP_AX_CFG 12'h010
`define AMP_AX_ERR 12'h014
`define AMP_FWD_RST 32'h7FFFFFFF
`define AMP_REV_RST 32'h80000000
`define AMP_ERL_RST 32'h00004000
`define AMP_CFG_OOE 0
`define AMP_CFG_MTREV 1
`define AMP_CTL_SWPOL 0
`define AMP_CTL_ABORT 1
`define AMP_CTL_RET 2
`define AMP_CTL_RESET 3
`define AMP_CMD_HERE 3:0
`define AMP_CMD_TGTAX 5:4
`define AMP_CMD_TGTGO 6
`define AMP_ST_ERR 0
`define AMP_ST_LIM 1
`define AMP_ST_REJ 2
`endif

// file: verilog/amp_pkg.sv
`include "amp_cfg.svh"
package amp_pkg;
   typedef struct packed {
      logic [1:0] htrans;
      logic [11:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
   } amp_ahb_req_t;
   typedef enum logic [2:0] {
      AMP_RUN = 3'b001,
      AMP_ERR_RTN = 3'b010,
      AMP_LIM_RTN = 3'b100
   } amp_rtn_t;
   typedef struct packed {
      logic fwd_sw;
      logic rev_sw;
   } amp_sw_t;
endpackage : amp_pkg

// file: verilog/amp_sync2.sv
`timescale 1ns/1ps
module amp_sync2 #(parameter int W = 1, parameter logic [W-1:0] RV = '0) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= RV;
         dout <= RV;
      end else begin
         s1_r <= din;
         dout <= s1_r;
      end
   end
endmodule : amp_sync2

// file: verilog/amp_top.sv
// Summary of operation
// - Refuse position targets beyond soft limits
// - Stop axis travel at soft limit
// - Off-on-error per axis, one enables
// - Excess error always kills drive, latched off only if enabled
// - Abort command kills drive if enabled
// - Low abort input kills drive if enabled
// - Drive stays off until reset or servo-here
// - Excess error starts error routine
// - Return command ends routine, resumes program
// - Error routine retriggers while error persists
// - Active limit switch blocks that direction
// - Switch hit while moving starts switch routine
// - Switch states readable for conditional jumps
// - Switch polarity set by configure command
// - Motor type reverse flips feedback polarity
// - Programmable output offset on drive
// - Abort stops motion at once, holds servo on axes without off-on-error
// - Active-low amp enable dropped on faults
`timescale 1ns/1ps
`include "amp_cfg.svh"
module amp_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic abort_n,
   input wire logic [`AMP_NAXES-1:0] fwd_sw_in,
   input wire logic [`AMP_NAXES-1:0] rev_sw_in,
   input wire logic watchdog,
   input wire logic [`AMP_NAXES*32-1:0] cmd_pos,
   input wire logic [`AMP_NAXES*32-1:0] act_pos,
   input wire logic [`AMP_NAXES-1:0] move_fwd,
   input wire logic [`AMP_NAXES-1:0] move_rev,
   output logic [`AMP_NAXES-1:0] amplifier_enable_n,
   output logic [`AMP_NAXES-1:0] inhibit_fwd,
   output logic [`AMP_NAXES-1:0] inhibit_rev,
   output logic [`AMP_NAXES-1:0] motion_stop,
   output logic [`AMP_NAXES*32-1:0] drive_out,
   output logic [2:0] routine,
   output logic irq
);
   import amp_pkg::*;
   localparam int N = `AMP_NAXES;

   function automatic logic [11:0] axaddr(input int ax, input logic [11:0] off);
      axaddr = 12'(`AMP_A_AXBASE + ax * `AMP_A_AXSTEP) + off;
   endfunction : axaddr

   function automatic logic [31:0] absdiff(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] d;
      d = a - b;
      absdiff = d[31] ? (32'h0 - d) : d;
   endfunction : absdiff

   // Pin synchronisers
   logic [2*N+1:0] pins_s;
   // Reset to idle pin levels so no false abort or switch edge follows reset
   amp_sync2 #(.W(2*N+2), .RV({1'b0, 1'b1, {(2*N){1'b1}}})) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .din({watchdog, abort_n, fwd_sw_in, rev_sw_in}),
      .dout(pins_s)
   );
   logic wdog_s, abort_n_s;
   logic [N-1:0] fsw_raw, rsw_raw;
   assign {wdog_s, abort_n_s, fsw_raw, rsw_raw} = pins_s;

   // Bus address phase capture
   amp_ahb_req_t req_r, req_nxt;
   logic [N-1:0][31:0] fwd_r, fwd_nxt, rev_r, rev_nxt, erl_r, erl_nxt, ofs_r, ofs_nxt;
   logic [N-1:0][1:0] cfg_r, cfg_nxt;
   logic swpol_r, swpol_nxt;
   logic [N-1:0] off_r, off_nxt;
   logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic [31:0] tgt_r, tgt_nxt;
   logic [31:0] rdata_nxt;
   logic irq_nxt;
   amp_rtn_t rtn_r, rtn_nxt;
   logic [N-1:0] en_n_nxt, inf_nxt, inr_nxt, stop_nxt;
   logic [N*32-1:0] drv_nxt;
   logic [N-1:0] fsw, rsw, excess, lim_hit;
   logic [N-1:0] lim_hit_d_r;
   logic [N-1:0][31:0] perr;

   logic wr, rd;
   assign wr = req_r.hsel && req_r.htrans[1] && req_r.hwrite;
   assign rd = hsel && htrans[1] && !hwrite && hready;

   logic ctl_wr, cmd_wr, ctl_abort, ctl_ret, ctl_reset, tgt_go, tgt_ok;
   logic [1:0] tgt_ax;
   assign ctl_wr = wr && req_r.haddr == `AMP_A_CTRL;
   assign cmd_wr = wr && req_r.haddr == `AMP_A_CMD;
   assign ctl_abort = ctl_wr && hwdata[`AMP_CTL_ABORT];
   assign ctl_ret = ctl_wr && hwdata[`AMP_CTL_RET];
   assign ctl_reset = ctl_wr && hwdata[`AMP_CTL_RESET];
   assign tgt_go = cmd_wr && hwdata[`AMP_CMD_TGTGO];
   assign tgt_ax = hwdata[`AMP_CMD_TGTAX];
   assign tgt_ok = $signed(tgt_r) <= $signed(fwd_r[tgt_ax])
      && $signed(tgt_r) >= $signed(rev_r[tgt_ax]);

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ax
         logic [31:0] cp, ap;
         assign cp = cmd_pos[g*32 +: 32];
         assign ap = act_pos[g*32 +: 32];
         // Feedback sign flip for reversed motor type
         assign perr[g] = cfg_r[g][`AMP_CFG_MTREV] ? (cp + ap) : (cp - ap);
         assign excess[g] = absdiff(perr[g], 32'h0) > erl_r[g];
         assign fsw[g] = fsw_raw[g] ^ ~swpol_r;
         assign rsw[g] = rsw_raw[g] ^ ~swpol_r;
         assign lim_hit[g] = (fsw[g] && move_fwd[g]) || (rsw[g] && move_rev[g]);
      end
   endgenerate

   always_comb begin
      req_nxt = req_r;
      if (hready) begin
         req_nxt.hsel = hsel;
         req_nxt.htrans = htrans;
         req_nxt.haddr = haddr[11:0];
         req_nxt.hwrite = hwrite;
         req_nxt.hsize = hsize;
      end
   end

   // Register writes and fault state
   always_comb begin
      fwd_nxt = fwd_r;
      rev_nxt = rev_r;
      erl_nxt = erl_r;
      ofs_nxt = ofs_r;
      cfg_nxt = cfg_r;
      swpol_nxt = swpol_r;
      tgt_nxt = tgt_r;
      mask_nxt = mask_r;
      off_nxt = off_r;
      stat_nxt = stat_r;
      for (int a = 0; a < N; a++) begin
         if (wr && req_r.haddr == axaddr(a, `AMP_AX_FWD)) fwd_nxt[a] = hwdata;
         if (wr && req_r.haddr == axaddr(a, `AMP_AX_REV)) rev_nxt[a] = hwdata;
         if (wr && req_r.haddr == axaddr(a, `AMP_AX_ERL)) erl_nxt[a] = hwdata;
         if (wr && req_r.haddr == axaddr(a, `AMP_AX_OFS)) ofs_nxt[a] = hwdata;
         if (wr && req_r.haddr == axaddr(a, `AMP_AX_CFG)) cfg_nxt[a] = hwdata[1:0];
         if (cmd_wr && hwdata[a]) off_nxt[a] = 1'b0;
         if (cfg_r[a][`AMP_CFG_OOE]) begin
            if (excess[a]) off_nxt[a] = 1'b1;
            if (ctl_abort) off_nxt[a] = 1'b1;
            if (!abort_n_s) off_nxt[a] = 1'b1;
         end
      end
      if (ctl_reset) off_nxt = '0;
      if (ctl_wr) swpol_nxt = hwdata[`AMP_CTL_SWPOL];
      if (wr && req_r.haddr == `AMP_A_TGT) tgt_nxt = hwdata;
      if (wr && req_r.haddr == `AMP_A_MASK) mask_nxt = hwdata[2:0];
      if (wr && req_r.haddr == `AMP_A_STAT) stat_nxt = stat_r & ~hwdata[2:0];
      // Set wins over clear
      if (|excess) stat_nxt[`AMP_ST_ERR] = 1'b1;
      if (|(lim_hit & ~lim_hit_d_r)) stat_nxt[`AMP_ST_LIM] = 1'b1;
      if (tgt_go && !tgt_ok) stat_nxt[`AMP_ST_REJ] = 1'b1;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // Routine dispatch
   always_comb begin
      rtn_nxt = rtn_r;
      unique case (rtn_r)
         AMP_RUN: begin
            if (|excess) rtn_nxt = AMP_ERR_RTN;
            else if (|(lim_hit & ~lim_hit_d_r)) rtn_nxt = AMP_LIM_RTN;
         end
         AMP_ERR_RTN: begin
            if (ctl_ret) rtn_nxt = AMP_RUN;
         end
         AMP_LIM_RTN: begin
            if (ctl_ret) rtn_nxt = AMP_RUN;
         end
      endcase
   end

   // Drive outputs
   always_comb begin
      for (int a = 0; a < N; a++) begin
         stop_nxt[a] = !abort_n_s || ctl_abort;
         inf_nxt[a] = fsw[a] || $signed(cmd_pos[a*32 +: 32]) >= $signed(fwd_r[a]);
         inr_nxt[a] = rsw[a] || $signed(cmd_pos[a*32 +: 32]) <= $signed(rev_r[a]);
         en_n_nxt[a] = off_nxt[a] || excess[a] || wdog_s;
         drv_nxt[a*32 +: 32] = en_n_nxt[a] ? 32'h0 : perr[a] + ofs_r[a];
      end
   end

   // Read mux, loaded at the address phase from next values
   // Next values let a read see a write that ends in the same edge
   always_comb begin
      rdata_nxt = 32'h0;
      unique case (haddr[11:0])
         `AMP_A_CTRL: rdata_nxt = {31'h0, swpol_nxt};
         `AMP_A_STAT: rdata_nxt = {29'h0, stat_nxt};
         `AMP_A_MASK: rdata_nxt = {29'h0, mask_nxt};
         `AMP_A_SW: rdata_nxt = {24'h0, fsw, rsw};
         `AMP_A_DRV: rdata_nxt = {28'h0, off_nxt};
         `AMP_A_TGT: rdata_nxt = tgt_nxt;
         default: begin
            for (int a = 0; a < N; a++) begin
               if (haddr[11:0] == axaddr(a, `AMP_AX_FWD)) rdata_nxt = fwd_nxt[a];
               if (haddr[11:0] == axaddr(a, `AMP_AX_REV)) rdata_nxt = rev_nxt[a];
               if (haddr[11:0] == axaddr(a, `AMP_AX_ERL)) rdata_nxt = erl_nxt[a];
               if (haddr[11:0] == axaddr(a, `AMP_AX_OFS)) rdata_nxt = ofs_nxt[a];
               if (haddr[11:0] == axaddr(a, `AMP_AX_CFG)) rdata_nxt = {30'h0, cfg_nxt[a]};
               if (haddr[11:0] == axaddr(a, `AMP_AX_ERR)) rdata_nxt = perr[a];
            end
         end
      endcase
      if (!rd) rdata_nxt = 32'h0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_r <= '0;
         for (int a = 0; a < N; a++) begin
            fwd_r[a] <= `AMP_FWD_RST;
            rev_r[a] <= `AMP_REV_RST;
            erl_r[a] <= `AMP_ERL_RST;
            ofs_r[a] <= 32'h0;
            cfg_r[a] <= 2'h0;
         end
         swpol_r <= 1'b0;
         off_r <= '0;
         stat_r <= 3'h0;
         mask_r <= 3'h0;
         tgt_r <= 32'h0;
         rtn_r <= AMP_RUN;
         lim_hit_d_r <= '0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= 1'b0;
         amplifier_enable_n <= '1;
         inhibit_fwd <= '0;
         inhibit_rev <= '0;
         motion_stop <= '0;
         drive_out <= '0;
         routine <= 3'h1;
      end else begin
         req_r <= req_nxt;
         fwd_r <= fwd_nxt;
         rev_r <= rev_nxt;
         erl_r <= erl_nxt;
         ofs_r <= ofs_nxt;
         cfg_r <= cfg_nxt;
         swpol_r <= swpol_nxt;
         off_r <= off_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         tgt_r <= tgt_nxt;
         rtn_r <= rtn_nxt;
         lim_hit_d_r <= lim_hit;
         hrdata <= rdata_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= irq_nxt;
         amplifier_enable_n <= en_n_nxt;
         inhibit_fwd <= inf_nxt;
         inhibit_rev <= inr_nxt;
         motion_stop <= stop_nxt;
         drive_out <= drv_nxt;
         routine <= rtn_nxt;
      end
   end
endmodule : amp_top
